// ---- rtl/iorl_top.sv ----
//
// Contract
// - port id 1..8 selects a general-purpose port, 9 the trigger-bus port.
// - reads accepted any time; input bits return current logical pin state.
// - bits configured as outputs return the last written value.
// - returned bits are logical; polarity maps on to high or low level.
// - fixed-direction ids: 0x03 reads input port 3, 0x82 output port 2; here 0x03 is plain port 3, output bits give written value.
// - trigger-bus reads return latched data so pulses between reads show.
// - latch is cleared after its value has been returned.
// - active level captured by the trigger latch follows that port's polarity.
// - destination 0xFF host, 0x01-0x78 variable, 0x81-0xF8 indirect, 0 discard.
// - trigger lines readable whatever their direction.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module iorl_top
   import iorl_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire logic                       ce,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [DATA_W-1:0]          s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [ADDR_W-1:0]          s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [DATA_W-1:0]               s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // general-purpose pins, port n in bits [8n-1 -: 8]
   input  wire logic [NUM_GP*PORT_W-1:0]   gp_pin_i,
   output logic      [NUM_GP*PORT_W-1:0]   gp_pin_o,
   output logic      [NUM_GP*PORT_W-1:0]   gp_pin_oe_n,
   // trigger-bus lines
   input  wire logic [PORT_W-1:0]          trig_pin_i,
   output logic      [PORT_W-1:0]          trig_pin_o,
   output logic      [PORT_W-1:0]          trig_pin_oe_n,
   // results routed to program variables
   output logic                            var_wr_valid,
   output logic                            var_wr_indirect,
   output logic [7:0]                      var_wr_dest,
   output logic [7:0]                      var_wr_data
);

   localparam int NPORT = NUM_GP + 1;

   // --------------------------------
   // state
   // --------------------------------
   logic [PORT_W-1:0]          out_reg [NPORT];
   logic [PORT_W-1:0]          dir_reg [NPORT];
   logic [PORT_W-1:0]          pol_reg [NPORT];
   iorl_cmd_s                  cmd_reg;
   logic                       go_reg;
   iorl_res_s                  res_reg;
   logic [ADDR_W-1:0]          awaddr_reg;
   logic [DATA_W-1:0]          wdata_reg;
   logic [3:0]                 wstrb_reg;
   logic                       aw_got_reg;
   logic                       w_got_reg;
   logic [NUM_GP*PORT_W-1:0]   gp_sync;
   logic [PORT_W-1:0]          trig_sync;
   logic [PORT_W-1:0]          trig_latch;
   logic [PORT_W-1:0]          trig_active;
   logic                       trig_clr;

   // --------------------------------
   // pin inputs
   // --------------------------------
   iorl_sync #(.W(NUM_GP*PORT_W)) u_gp_sync
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .ce      (ce),
      .d       (gp_pin_i),
      .q       (gp_sync)
   );

   // lines sampled even while driven, so they always read back
   iorl_sync #(.W(PORT_W)) u_trig_sync
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .ce      (ce),
      .d       (trig_pin_i),
      .q       (trig_sync)
   );

   // polarity decides which level counts as active for capture
   assign trig_active = trig_sync ^ pol_reg[NUM_GP];

   iorl_trig_latch #(.W(PORT_W)) u_trig_latch
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .ce      (ce),
      .active  (trig_active),
      .clr     (trig_clr),
      .q       (trig_latch)
   );

   // --------------------------------
   // address decode helpers
   // --------------------------------
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      return (a >= base) && (a < base + REG_SPAN) && (a[1:0] == 2'b00);
   endfunction

   function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      return int'(off[7:2]);
   endfunction

   function automatic logic dest_ok(input logic [7:0] d);
      return (d == DST_NONE) || (d == DST_HOST)
          || (d >= DST_VAR_LO && d <= DST_VAR_HI)
          || (d >= DST_IND_LO && d <= DST_IND_HI);
   endfunction

   function automatic logic port_ok(input logic [7:0] p);
      logic [7:0] low;
      low = p & ~ID_OUT_FLAG;
      if (p[7])
         return low >= ID_GP_FIRST && low <= ID_GP_LAST;
      return p >= ID_GP_FIRST && p <= ID_TRIG;
   endfunction

   // --------------------------------
   // axi write channel
   // --------------------------------
   logic wr_fire;
   assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
   logic wr_hit;
   assign wr_hit = in_bank(awaddr_reg, OFS_OUT_BASE) || in_bank(awaddr_reg, OFS_DIR_BASE)
                || in_bank(awaddr_reg, OFS_POL_BASE) || awaddr_reg == OFS_CMD;

   // address and data caught independently, in either order
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         wstrb_reg     <= '0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg    <= s_axi_awaddr;
            aw_got_reg    <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            w_got_reg    <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // configuration registers; only byte lane 0 holds data
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NPORT; i++)
         begin
            out_reg[i] <= RST_OUT;
            dir_reg[i] <= RST_DIR;
            pol_reg[i] <= RST_POL;
         end
      end
      else if (ce && wr_fire && wstrb_reg[0])
      begin
         if (in_bank(awaddr_reg, OFS_OUT_BASE))
            out_reg[bank_idx(awaddr_reg, OFS_OUT_BASE)] <= wdata_reg[7:0];
         if (in_bank(awaddr_reg, OFS_DIR_BASE))
            dir_reg[bank_idx(awaddr_reg, OFS_DIR_BASE)] <= wdata_reg[7:0];
         if (in_bank(awaddr_reg, OFS_POL_BASE))
            pol_reg[bank_idx(awaddr_reg, OFS_POL_BASE)] <= wdata_reg[7:0];
      end
   end

   // a command write with byte lanes 0 and 1 both strobed launches a read; a newer one simply follows
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_reg <= '0;
         go_reg  <= 1'b0;
      end
      else if (ce)
      begin
         go_reg <= 1'b0;
         if (wr_fire && awaddr_reg == OFS_CMD && (&wstrb_reg[1:0]))
         begin
            cmd_reg <= iorl_cmd_s'(wdata_reg[15:0]);
            go_reg  <= 1'b1;
         end
      end
   end

   // --------------------------------
   // port read execution
   // --------------------------------
   logic            cmd_ok;
   logic [7:0]      sel_low;
   logic [3:0]      sel_idx;
   logic [7:0]      rd_val;

   assign cmd_ok  = port_ok(cmd_reg.port) && dest_ok(cmd_reg.dest);
   assign sel_low = cmd_reg.port & ~ID_OUT_FLAG;
   assign sel_idx = sel_low[3:0] - 4'h1;

   // clear only on a good trigger-bus read, never on a rejected one
   assign trig_clr = go_reg && cmd_ok && cmd_reg.port == ID_TRIG;

   // logical value of the selected port
   always_comb
   begin
      rd_val = '0;
      if (cmd_reg.port == ID_TRIG)
         rd_val = trig_latch;
      else if (cmd_reg.port[7])
         rd_val = out_reg[sel_idx];
      else if (sel_idx < 4'(NUM_GP))
         for (int b = 0; b < PORT_W; b++)
            rd_val[b] = dir_reg[sel_idx][b]
                      ? gp_sync[sel_idx*PORT_W+b] ^ pol_reg[sel_idx][b]
                      : out_reg[sel_idx][b];
   end

   // result word and routing to program variables
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         res_reg         <= '0;
         var_wr_valid    <= 1'b0;
         var_wr_indirect <= 1'b0;
         var_wr_dest     <= '0;
         var_wr_data     <= '0;
      end
      else if (ce)
      begin
         var_wr_valid <= 1'b0;
         if (go_reg)
         begin
            res_reg.done <= 1'b1;
            res_reg.err  <= !cmd_ok;
            res_reg.dest <= cmd_reg.dest;
            // discarded or rejected reads leave no data behind
            res_reg.data <= (cmd_ok && cmd_reg.dest != DST_NONE) ? rd_val : '0;
            if (cmd_ok && cmd_reg.dest != DST_NONE && cmd_reg.dest != DST_HOST)
            begin
               var_wr_valid    <= 1'b1;
               var_wr_indirect <= cmd_reg.dest[7];
               var_wr_dest     <= cmd_reg.dest;
               var_wr_data     <= rd_val;
            end
         end
         else if (wr_fire && awaddr_reg == OFS_CMD)
            res_reg.done <= 1'b0;
      end
   end

   // --------------------------------
   // pin drive: outputs carry logical value through polarity
   // --------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gp_pin_o      <= '0;
         gp_pin_oe_n   <= '1;
         trig_pin_o    <= '0;
         trig_pin_oe_n <= '1;
      end
      else if (ce)
      begin
         for (int p = 0; p < NUM_GP; p++)
         begin
            gp_pin_o[p*PORT_W +: PORT_W]    <= out_reg[p] ^ pol_reg[p];
            gp_pin_oe_n[p*PORT_W +: PORT_W] <= dir_reg[p];
         end
         trig_pin_o    <= out_reg[NUM_GP] ^ pol_reg[NUM_GP];
         trig_pin_oe_n <= dir_reg[NUM_GP];
      end
   end

   // --------------------------------
   // axi read channel
   // --------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
            // looking at the latch here never clears it
            if (in_bank(s_axi_araddr, OFS_OUT_BASE))
               s_axi_rdata[7:0] <= out_reg[bank_idx(s_axi_araddr, OFS_OUT_BASE)];
            else if (in_bank(s_axi_araddr, OFS_DIR_BASE))
               s_axi_rdata[7:0] <= dir_reg[bank_idx(s_axi_araddr, OFS_DIR_BASE)];
            else if (in_bank(s_axi_araddr, OFS_POL_BASE))
               s_axi_rdata[7:0] <= pol_reg[bank_idx(s_axi_araddr, OFS_POL_BASE)];
            else if (s_axi_araddr == OFS_CMD)
               s_axi_rdata[15:0] <= cmd_reg;
            else if (s_axi_araddr == OFS_RES)
               s_axi_rdata[RES_ERR_BIT:0] <= res_reg;
            else if (s_axi_araddr == OFS_LATCH)
               s_axi_rdata[7:0] <= trig_latch;
            else
               s_axi_rresp <= RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ---- rtl/iorl_pkg.sv ----
package iorl_pkg;

   // --------------------------------
   // bus and register map
   // --------------------------------
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam logic [7:0]  OFS_OUT_BASE = 8'h00;  // 9 words, port n at base + 4*(n-1)
   localparam logic [7:0]  OFS_DIR_BASE = 8'h40;
   localparam logic [7:0]  OFS_POL_BASE = 8'h80;
   localparam logic [7:0]  OFS_CMD      = 8'hC0;
   localparam logic [7:0]  OFS_RES      = 8'hC4;
   localparam logic [7:0]  OFS_LATCH    = 8'hC8;
   localparam logic [7:0]  REG_SPAN     = 8'h24;  // 9 words per bank

   localparam logic [7:0]  RST_OUT      = 8'h00;
   localparam logic [7:0]  RST_DIR      = 8'hFF;  // every bit an input
   localparam logic [7:0]  RST_POL      = 8'h00;  // on means high

   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   // --------------------------------
   // port identifiers and return destinations
   // --------------------------------
   localparam int          NUM_GP       = 8;
   localparam int          PORT_W       = 8;
   localparam logic [7:0]  ID_GP_FIRST  = 8'h01;
   localparam logic [7:0]  ID_GP_LAST   = 8'h08;
   localparam logic [7:0]  ID_TRIG      = 8'h09;
   localparam logic [7:0]  ID_OUT_FLAG  = 8'h80;  // fixed-direction output view
   localparam logic [7:0]  DST_NONE     = 8'h00;
   localparam logic [7:0]  DST_VAR_LO   = 8'h01;
   localparam logic [7:0]  DST_VAR_HI   = 8'h78;
   localparam logic [7:0]  DST_IND_LO   = 8'h81;
   localparam logic [7:0]  DST_IND_HI   = 8'hF8;
   localparam logic [7:0]  DST_HOST     = 8'hFF;

   // result word fields
   localparam int          RES_DONE_BIT = 16;
   localparam int          RES_ERR_BIT  = 17;

   typedef struct packed {
      logic [7:0] dest;
      logic [7:0] port;
   } iorl_cmd_s;

   typedef struct packed {
      logic       err;
      logic       done;
      logic [7:0] dest;
      logic [7:0] data;
   } iorl_res_s;

endpackage

// ---- rtl/iorl_sync.sv ----
`timescale 1ns/1ps

// two-flop synchroniser bank for pin inputs
module iorl_sync
   import iorl_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else if (ce)
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// ---- rtl/iorl_trig_latch.sv ----
`timescale 1ns/1ps

// sticky capture of active trigger-bus pulses
module iorl_trig_latch
   import iorl_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [W-1:0] active,
   input  wire logic         clr,
   output logic      [W-1:0] q
);

   // a pulse in the clearing cycle survives: set wins over clear
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         q <= '0;
      else if (ce)
         q <= (clr ? '0 : q) | active;
   end

endmodule

// ---- test/iorl_chk_asserts.sv ----
`timescale 1ns/1ps

// --------------------------------
// port-level checks of the bus slave and the result router
// --------------------------------
module iorl_chk
   import iorl_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic              s_axi_awvalid,
   input  wire logic              s_axi_awready,
   input  wire logic              s_axi_wvalid,
   input  wire logic              s_axi_wready,
   input  wire logic [1:0]        s_axi_bresp,
   input  wire logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   input  wire logic              s_axi_arready,
   input  wire logic [DATA_W-1:0] s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp,
   input  wire logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              var_wr_valid,
   input  wire logic              var_wr_indirect,
   input  wire logic [7:0]        var_wr_dest,
   input  wire logic [7:0]        var_wr_data
);
   // one domain, so one clock and one disable for all
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer not held");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr > OFS_LATCH |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   var_dest_a: assert property (var_wr_valid |-> var_wr_indirect == var_wr_dest[7]
      && var_wr_dest inside {[DST_VAR_LO:DST_VAR_HI], [DST_IND_LO:DST_IND_HI]})
      else $error("bad routed destination");
   var_pulse_a: assert property (var_wr_valid |=> !var_wr_valid)
      else $error("routing strobe too long");
   var_hold_a: assert property (!var_wr_valid |->
      $stable(var_wr_dest) && $stable(var_wr_data))
      else $error("routed result moved");
endmodule

bind iorl_top iorl_chk iorl_chk_i (
   .sys_clk(sys_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .var_wr_valid(var_wr_valid), .var_wr_indirect(var_wr_indirect),
   .var_wr_dest(var_wr_dest), .var_wr_data(var_wr_data));

// ---- test/iorl_pin_env.sv ----
`timescale 1ns/1ps

// --------------------------------
// outside world of the pins
// --------------------------------
module iorl_pin_env
   import iorl_pkg::*;
(
   input  wire logic [NUM_GP*PORT_W-1:0] ext_gp,
   input  wire logic [PORT_W-1:0]        ext_trig,
   input  wire logic [NUM_GP*PORT_W-1:0] gp_o,
   input  wire logic [NUM_GP*PORT_W-1:0] gp_oe_n,
   input  wire logic [PORT_W-1:0]        trig_o,
   input  wire logic [PORT_W-1:0]        trig_oe_n,
   output logic      [NUM_GP*PORT_W-1:0] gp_pin,
   output logic      [PORT_W-1:0]        trig_pin
);
   // driven bits show the block's level, undriven ones the outside
   assign gp_pin   = (gp_o & ~gp_oe_n) | (ext_gp & gp_oe_n);
   assign trig_pin = (trig_o & ~trig_oe_n) | (ext_trig & trig_oe_n);
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps

module testbench
   import iorl_pkg::*;
   ;
   logic                       sys_clk, rstn, ce;
   logic [ADDR_W-1:0]          s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0]          s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0]                 s_axi_wstrb;
   logic [1:0]                 s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                       s_axi_rvalid, s_axi_rready, var_wr_valid, var_wr_indirect;
   logic [7:0]                 var_wr_dest, var_wr_data, ext_trig, trig_pin_i;
   logic [7:0]                 trig_pin_o, trig_pin_oe_n;
   logic [NUM_GP*PORT_W-1:0]   ext_gp, gp_pin_i, gp_pin_o, gp_pin_oe_n;
   logic [7:0]                 m_out [1:9];
   logic [7:0]                 m_dir [1:9];
   logic [7:0]                 m_pol [1:9];
   logic [7:0]                 rstv [3] = '{RST_OUT, RST_DIR, RST_POL};
   logic [7:0]                 dests [6] = '{DST_NONE, DST_VAR_LO, DST_VAR_HI,
                                             DST_IND_LO, DST_IND_HI, DST_HOST};
   logic [15:0]                bad [5] = '{16'hFF00, 16'hFF0A, 16'hFF89, 16'h7909, 16'h8009};
   int                         failures, comparisons, cycles, routed;

   iorl_top iorl_top_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gp_pin_i(gp_pin_i),
      .gp_pin_o(gp_pin_o), .gp_pin_oe_n(gp_pin_oe_n), .trig_pin_i(trig_pin_i),
      .trig_pin_o(trig_pin_o), .trig_pin_oe_n(trig_pin_oe_n),
      .var_wr_valid(var_wr_valid), .var_wr_indirect(var_wr_indirect),
      .var_wr_dest(var_wr_dest), .var_wr_data(var_wr_data));

   iorl_pin_env iorl_pin_env_i (.ext_gp(ext_gp), .ext_trig(ext_trig), .gp_o(gp_pin_o),
      .gp_oe_n(gp_pin_oe_n), .trig_o(trig_pin_o), .trig_oe_n(trig_pin_oe_n),
      .gp_pin(gp_pin_i), .trig_pin(trig_pin_i));

   // --------------------------------
   // clock, hang limit and verdict
   // --------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // routing strobes counted; limit far above a normal run
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (var_wr_valid)
         routed <= routed + 1;
      if (cycles == 20000)
      begin
         failures++;
         final_report;
      end
   end

   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // --------------------------------
   // bus master and reference model
   // --------------------------------
   // address and data released separately, each when its own ready is seen
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_p, w_p;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      aw_p = 1'b1;
      w_p  = 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge sys_clk);
         if (s_axi_awready)
            aw_p = 1'b0;
         if (s_axi_wready)
            w_p = 1'b0;
         s_axi_awvalid <= aw_p;
         s_axi_wvalid  <= w_p;
      end
      do @(posedge sys_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;  // answer kept waiting a cycle
      do @(posedge sys_clk); while (!s_axi_bvalid);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;  // answer kept waiting a cycle
      do @(posedge sys_clk); while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // input bits give pin level through polarity, output bits the written value
   function automatic logic [7:0] gp_val(input int p);
      logic [7:0] pin;
      pin = ext_gp[8*p-1 -: 8];
      gp_val = (m_dir[p] & (pin ^ m_pol[p])) | (~m_dir[p] & m_out[p]);
   endfunction

   // one port read, result word and routed copy compared
   task automatic cmd(input logic [7:0] id, input logic [7:0] dst, input logic ok,
                      input logic [7:0] val);
      logic [7:0] d;
      int         rt;
      d  = (ok && dst != DST_NONE) ? val : 8'h00;
      rt = routed;
      axw(OFS_CMD, {16'h0000, dst, id});
      axr(OFS_RES);
      check(rd_data, {14'h0000, !ok, 1'b1, dst, d});
      check(routed - rt, {31'h0, ok && dst != DST_NONE && dst != DST_HOST});
      if (ok && dst != DST_NONE && dst != DST_HOST)
         check({var_wr_indirect, var_wr_dest, var_wr_data}, {dst[7], dst, d});
   endtask

   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      int p, r, b;
      logic [7:0] pm;
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_gp, ext_trig} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      void'($urandom(9220));
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values of every bank, then a hole in the map both ways
      for (b = 0; b < 3; b++)
         for (p = 1; p < 10; p++)
         begin
            axr(8'(64*b + 4*p - 4));
            check(rd_data, {24'h000000, rstv[b]});
         end
      axr(8'hD0);
      check({rd_resp, rd_data}, {RESP_SLVERR, 32'h00000000});
      axw(8'hD0, 32'h00000001);
      check(wr_resp, RESP_SLVERR);
      // general-purpose ports with random direction, polarity and pins
      for (r = 0; r < 4; r++)
      begin
         ext_gp <= {$urandom, $urandom};
         for (p = 1; p < 9; p++)
         begin
            m_out[p] = 8'($urandom);
            m_dir[p] = 8'($urandom);
            m_pol[p] = 8'($urandom);
            axw(8'(4*p - 4), {24'h000000, m_out[p]});
            axw(8'(4*p + 60), {24'h000000, m_dir[p]});
            axw(8'(4*p + 124), {24'h000000, m_pol[p]});
         end
         for (p = 1; p < 9; p++)
         begin
            cmd(8'(p), dests[(p + r) % 6], 1'b1, gp_val(p));
            cmd(8'(p) | ID_OUT_FLAG, dests[(p + r + 3) % 6], 1'b1, m_out[p]);
            check({gp_pin_oe_n[8*p-1 -: 8], gp_pin_o[8*p-1 -: 8]},
                  {m_dir[p], m_out[p] ^ m_pol[p]});
         end
      end
      // trigger port: output bits held active, input bits pulsed, then reads
      for (r = 0; r < 3; r++)
      begin
         pm = 8'($urandom);
         m_pol[9] = 8'($urandom);
         m_dir[9] = (r == 0) ? 8'hFF : 8'($urandom);
         m_out[9] = pm & ~m_dir[9];
         ext_trig <= m_pol[9];
         axw(8'h20, {24'h000000, m_out[9]});
         axw(8'h60, {24'h000000, m_dir[9]});
         axw(8'hA0, {24'h000000, m_pol[9]});
         cmd(ID_TRIG, DST_NONE, 1'b1, 8'h00);
         ext_trig <= m_pol[9] ^ (pm & m_dir[9]);
         repeat (3) @(posedge sys_clk);
         ext_trig <= m_pol[9];
         foreach (bad[i])
            cmd(bad[i][7:0], bad[i][15:8], 1'b0, 8'h00);
         axr(OFS_LATCH);
         check(rd_data, {24'h000000, pm});
         cmd(ID_TRIG, DST_HOST, 1'b1, pm);
         cmd(ID_TRIG, dests[r + 1], 1'b1, m_out[9]);
      end
      final_report;
   end
endmodule
